// ### design/rcs_relay_card.sv
// Relay card array: serial driver chains, output latches, power-on safeguard, register slave
// Summary of operation
// - One shift clock, data, ident line shared.
// - Own select per card gates data and ident.
// - Bytes shift along the driver chain serially.
// - Strobe moves shifted bits into output latches.
// - Low driver output energizes, high releases relay.
// - Strobe reaches every card, selected or not.
// - Safeguard comes up set, outputs disabled.
// - First armed strobe fall enables the outputs.
// - Strobe falls ignored during the hold-off time.
// - Each ident byte costs one relay byte.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module rcs_relay_card
#(
    parameter int unsigned STAGES         = rcs_pkg::DEF_STAGES,
    parameter int unsigned HOLDOFF_CYCLES = rcs_pkg::HOLDOFF_CYC
)
(
    // Core clock and reset
    input  wire logic                                            CORE_CLK_I,
    input  wire logic                                            RST_B_I,
    // Avalon-MM slave
    input  wire logic [7:0]                                      AVS_ADDRESS_I,
    input  wire logic                                            AVS_READ_I,
    input  wire logic                                            AVS_WRITE_I,
    input  wire logic [31:0]                                     AVS_WRITEDATA_I,
    input  wire logic [3:0]                                      AVS_BYTEENABLE_I,
    output logic      [31:0]                                     AVS_READDATA_O,
    output logic                                                 AVS_WAITREQUEST_O,
    // Serial link from the host
    input  wire logic                                            SHIFT_CLK_I,
    input  wire logic                                            RELAY_SERIAL_OUT_I,
    input  wire logic [rcs_pkg::NUM_CARDS-1:0]                   CARD_SELECT_N_I,
    input  wire logic                                            LATCH_STROBE_I,
    output logic                                                 CARD_IDENT_SERIAL_IN_O,
    output logic                                                 CARD_IDENT_SERIAL_IN_OE_O,
    // Relay driver outputs
    output logic [rcs_pkg::NUM_CARDS-1:0]                        DRIVER_OUTPUT_ENABLE_N_O,
    output logic [rcs_pkg::NUM_CARDS*STAGES*rcs_pkg::STAGE_BITS-1:0] RELAY_DRIVE_N_O
);
    import rcs_pkg::*;

    localparam int unsigned CW = STAGES * STAGE_BITS;

    // Link domain state
    logic [CW-1:0]              chain_reg   [NUM_CARDS];
    logic [2:0]                 bitcnt_reg  [NUM_CARDS];
    // Core domain state
    logic [CW-1:0]              latch_reg   [NUM_CARDS];
    logic [IDENT_BITS-1:0]      ident_reg   [NUM_CARDS];
    logic [IDENT_BITS-1:0]      ident_next  [NUM_CARDS];
    logic [2:0]                 strobe_reg;
    logic [2:0]                 strobe_next;
    logic [NUM_CARDS-1:0]       en_n_reg;
    logic [NUM_CARDS-1:0]       en_n_next;
    logic [HOLDOFF_CNT_W-1:0]   holdoff_cnt_reg;
    logic [HOLDOFF_CNT_W-1:0]   holdoff_cnt_next;
    logic                       holdoff_done_reg;
    logic                       holdoff_done_next;
    logic                       ack_reg;
    logic                       ack_next;
    logic [31:0]                rdata_reg;
    logic [31:0]                rdata_next;
    logic                       strobe_rise;
    logic                       strobe_fall;
    logic                       bus_req;
    logic                       wr_take;

    // Strobe is asynchronous to the core clock; only stages 1 and 2 feed the edge logic
    always_comb
    begin
        strobe_next = {strobe_reg[1], strobe_reg[0], LATCH_STROBE_I};
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            strobe_reg <= 3'h0;
        else
            strobe_reg <= strobe_next;
    end

    assign strobe_rise = strobe_reg[1] & ~strobe_reg[2];
    assign strobe_fall = ~strobe_reg[1] & strobe_reg[2];

    // Hold-off timer starts at reset release, which stands in for power-up
    always_comb
    begin
        holdoff_cnt_next  = holdoff_cnt_reg;
        holdoff_done_next = holdoff_done_reg;
        if (!holdoff_done_reg)
        begin
            if (holdoff_cnt_reg >= HOLDOFF_CNT_W'(HOLDOFF_CYCLES - 1))
                holdoff_done_next = 1'b1;
            else
                holdoff_cnt_next = holdoff_cnt_reg + 24'h000001;
        end
    end

    // Safeguard latch: set by reset, cleared only by an armed strobe fall
    always_comb
    begin
        en_n_next = en_n_reg;
        if (strobe_fall && holdoff_done_reg)
            en_n_next = '0;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            holdoff_cnt_reg  <= '0;
            holdoff_done_reg <= 1'b0;
            en_n_reg         <= EN_N_RST;
        end
        else
        begin
            holdoff_cnt_reg  <= holdoff_cnt_next;
            holdoff_done_reg <= holdoff_done_next;
            en_n_reg         <= en_n_next;
        end
    end

    assign DRIVER_OUTPUT_ENABLE_N_O = en_n_reg;

    // Avalon slave: one wait state, so read data is a registered value
    assign bus_req           = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
    assign wr_take           = AVS_WRITE_I & ack_reg;
    assign AVS_READDATA_O    = rdata_reg;

    always_comb
    begin
        ack_next   = bus_req & ~ack_reg;
        rdata_next = rdata_reg;
        if (AVS_READ_I && !ack_reg)
        begin
            rdata_next = 32'h00000000;
            if (AVS_ADDRESS_I == ADDR_STATUS)
            begin
                rdata_next[STATUS_EN_N_LSB +: NUM_CARDS] = en_n_reg;
                rdata_next[STATUS_HOLDOFF_BIT]           = holdoff_done_reg;
            end
            for (int c = 0; c < NUM_CARDS; c++)
            begin
                if (AVS_ADDRESS_I == ADDR_IDENT_BASE + 8'(ADDR_STEP * c))
                    rdata_next[IDENT_BITS-1:0] = ident_reg[c];
                if (AVS_ADDRESS_I == ADDR_RELAY_BASE + 8'(ADDR_STEP * c))
                    rdata_next[CW-1:0] = latch_reg[c];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Shared return line: only selected cards put a bit on it
    always_comb
    begin
        CARD_IDENT_SERIAL_IN_O    = 1'b0;
        CARD_IDENT_SERIAL_IN_OE_O = 1'b0;
        for (int c = 0; c < NUM_CARDS; c++)
        begin
            if (!CARD_SELECT_N_I[c])
            begin
                CARD_IDENT_SERIAL_IN_O    = CARD_IDENT_SERIAL_IN_O |
                                            ident_reg[c][3'h7 - bitcnt_reg[c]];
                CARD_IDENT_SERIAL_IN_OE_O = 1'b1;
            end
        end
    end

    for (genvar c = 0; c < NUM_CARDS; c++)
    begin : g_card
        logic [CW-1:0] chain_next;
        logic [2:0]    bitcnt_next;
        logic [CW-1:0] latch_next;

        // Select and data change with the host's shift clock, so no synchroniser here
        always_comb
        begin
            chain_next  = chain_reg[c];
            bitcnt_next = bitcnt_reg[c];
            if (!CARD_SELECT_N_I[c])
            begin
                // Low bits are the first stage; each stage's top bit feeds the next
                chain_next  = {chain_reg[c][CW-2:0], RELAY_SERIAL_OUT_I};
                bitcnt_next = bitcnt_reg[c] + 3'h1;
            end
        end

        always_ff @(posedge SHIFT_CLK_I or negedge RST_B_I)
        begin
            if (!RST_B_I)
            begin
                chain_reg[c]  <= '0;
                bitcnt_reg[c] <= 3'h0;
            end
            else
            begin
                chain_reg[c]  <= chain_next;
                bitcnt_reg[c] <= bitcnt_next;
            end
        end

        // Chain is still while strobe is high, so the word is captured quasi-static
        always_comb
        begin
            latch_next    = latch_reg[c];
            ident_next[c] = ident_reg[c];
            if (strobe_rise)
                latch_next = chain_reg[c];
            if (wr_take && AVS_BYTEENABLE_I[0] &&
                AVS_ADDRESS_I == ADDR_IDENT_BASE + 8'(ADDR_STEP * c))
                ident_next[c] = AVS_WRITEDATA_I[IDENT_BITS-1:0];
        end

        always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
        begin
            if (!RST_B_I)
            begin
                latch_reg[c] <= '1;
                ident_reg[c] <= IDENT_RST;
            end
            else
            begin
                latch_reg[c] <= latch_next;
                ident_reg[c] <= ident_next[c];
            end
        end

        // Disabled driver leaves its relays released
        assign RELAY_DRIVE_N_O[c*CW +: CW] = en_n_reg[c] ? '1 : latch_reg[c];

        property p_shift_in;
            @(posedge SHIFT_CLK_I) disable iff (!RST_B_I)
            !CARD_SELECT_N_I[c] |=> chain_reg[c][0] == $past(RELAY_SERIAL_OUT_I) &&
                chain_reg[c][CW-1:1] == $past(chain_reg[c][CW-2:0]);
        endproperty
        a_shift_in : assert property (p_shift_in)
            else $error("chain did not shift in the serial bit");

        property p_unselected_still;
            @(posedge SHIFT_CLK_I) disable iff (!RST_B_I)
            CARD_SELECT_N_I[c] |=> $stable(chain_reg[c]) && $stable(bitcnt_reg[c]);
        endproperty
        a_unselected_still : assert property (p_unselected_still)
            else $error("unselected card shifted");

        property p_latch_on_rise;
            @(posedge CORE_CLK_I) disable iff (!RST_B_I)
            strobe_rise |=> latch_reg[c] == $past(chain_reg[c]);
        endproperty
        a_latch_on_rise : assert property (p_latch_on_rise)
            else $error("latch missed the strobe");

        property p_latch_hold;
            @(posedge CORE_CLK_I) disable iff (!RST_B_I)
            !strobe_rise |=> $stable(latch_reg[c]);
        endproperty
        a_latch_hold : assert property (p_latch_hold)
            else $error("latch changed between strobes");

        property p_drive_polarity;
            @(posedge CORE_CLK_I) disable iff (!RST_B_I)
            en_n_reg[c] |-> &RELAY_DRIVE_N_O[c*CW +: CW];
        endproperty
        a_drive_polarity : assert property (p_drive_polarity)
            else $error("relay driven while outputs disabled");
    end

    sequence s_armed_fall;
        strobe_fall && holdoff_done_reg;
    endsequence

    property p_enable_on_fall;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        s_armed_fall |=> en_n_reg == '0;
    endproperty
    a_enable_on_fall : assert property (p_enable_on_fall)
        else $error("armed strobe fall did not enable outputs");

    property p_enable_sticky;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        en_n_reg == '0 |=> en_n_reg == '0;
    endproperty
    a_enable_sticky : assert property (p_enable_sticky)
        else $error("outputs disabled again after enable");

    property p_holdoff_guard;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        !holdoff_done_reg |-> &en_n_reg;
    endproperty
    a_holdoff_guard : assert property (p_holdoff_guard)
        else $error("outputs enabled inside hold-off");

    property p_enable_cause;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        $fell(en_n_reg[0]) |-> $past(holdoff_done_reg) &&
            $past(strobe_reg[2]) && !strobe_reg[2];
    endproperty
    a_enable_cause : assert property (p_enable_cause)
        else $error("outputs enabled without an armed strobe fall");

    property p_bus_answer;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        bus_req && !ack_reg |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
    endproperty
    a_bus_answer : assert property (p_bus_answer)
        else $error("bus answer not after one wait state");
endmodule

// ### design/rcs_pkg.sv
// Constants shared by the relay card serial control block
package rcs_pkg;
    // Card slots on the shared serial link
    localparam int unsigned NUM_CARDS          = 6;
    // Bits held by one latched driver stage
    localparam int unsigned STAGE_BITS         = 8;
    // Default number of driver stages chained on one card
    localparam int unsigned DEF_STAGES         = 2;
    // Bits in one identification byte
    localparam int unsigned IDENT_BITS         = 8;

    // Core clock and the power-up hold-off
    localparam int unsigned CORE_CLK_HZ        = 20_000_000;
    localparam int unsigned HOLDOFF_MS         = 470;
    localparam int unsigned HOLDOFF_CYC        = HOLDOFF_MS * (CORE_CLK_HZ / 1000);
    localparam int unsigned HOLDOFF_CNT_W      = 24;

    // Register byte addresses, one 32-bit word each
    localparam logic [7:0]  ADDR_STATUS        = 8'h00;
    localparam logic [7:0]  ADDR_IDENT_BASE    = 8'h10;
    localparam logic [7:0]  ADDR_RELAY_BASE    = 8'h40;
    localparam logic [7:0]  ADDR_STEP          = 8'h04;

    // Status word fields
    localparam int unsigned STATUS_EN_N_LSB    = 0;
    localparam int unsigned STATUS_HOLDOFF_BIT = 8;

    // Reset values
    localparam logic [7:0]  IDENT_RST          = 8'h00;
    localparam logic [5:0]  EN_N_RST           = 6'h3F;
endpackage

// ### sim/rcs_host_model.sv
// Host side model: shift clock, relay data, card selects and strobe
`timescale 1ns/1ps
module rcs_host_model
(
    // Link toward the cards
    output logic       shift_clk_o,
    output logic       data_o,
    output logic [5:0] sel_n_o,
    output logic       strobe_o,
    // Shared ident return line
    input  wire logic  ident_i
);
    // Selects and strobe are bits of one port register
    logic [6:0] port_reg;
    assign sel_n_o  = port_reg[5:0];
    assign strobe_o = port_reg[6];
    // Port comes up undefined, so the strobe starts high
    initial
    begin
        port_reg    = 7'h7F;
        shift_clk_o = 1'b0;
        data_o      = 1'b0;
    end
    // Clock only runs inside a byte and stands low between bytes
    task automatic send_byte(input logic [5:0] sel_n, input logic [7:0] b,
                             output logic [7:0] id);
        port_reg[5:0] = sel_n;
        #40;
        for (int i = 7; i >= 0; i--)
        begin
            data_o = b[i];
            #32;
            id[i] = ident_i;
            shift_clk_o = 1'b1;
            #32;
            shift_clk_o = 1'b0;
        end
        #32;
        port_reg[5:0] = 6'h3F;
        // Released data line must not keep its last bit
        data_o = ~data_o;
    endtask
    task automatic set_strobe(input logic lvl);
        port_reg[6] = lvl;
    endtask
    // Long enough for the two-stage synchroniser on each level
    task automatic pulse();
        port_reg[6] = 1'b1;
        #400;
        port_reg[6] = 1'b0;
        #400;
    endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the relay card block
`timescale 1ns/1ps
module tb;
    import rcs_pkg::*;
    localparam int unsigned ST = 2;
    localparam int unsigned CW = ST * STAGE_BITS;
    logic                    clk;
    logic                    rst_n;
    logic [7:0]              addr;
    logic                    rd;
    logic                    wr;
    logic [31:0]             wdata;
    logic [3:0]              be;
    logic [31:0]             rdata;
    logic                    waitreq;
    logic                    sclk;
    logic                    sdata;
    logic [5:0]              sel_n;
    logic                    strobe;
    logic                    id_o;
    logic                    id_oe;
    logic                    id_wire;
    logic [5:0]              en_n;
    logic [NUM_CARDS*CW-1:0] drive_n;
    int                      bad_count;
    int                      check_count;
    int                      cyc;
    logic [31:0]             r;
    logic [7:0]              id;
    logic [7:0]              hi [NUM_CARDS];
    logic [7:0]              lo [NUM_CARDS];
    // Shared ident line has a pull-up
    assign id_wire = id_oe ? id_o : 1'b1;
    rcs_relay_card #(.STAGES(ST), .HOLDOFF_CYCLES(50)) dut_u
    (
        .CORE_CLK_I(clk), .RST_B_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .SHIFT_CLK_I(sclk),
        .RELAY_SERIAL_OUT_I(sdata), .CARD_SELECT_N_I(sel_n), .LATCH_STROBE_I(strobe),
        .CARD_IDENT_SERIAL_IN_O(id_o), .CARD_IDENT_SERIAL_IN_OE_O(id_oe),
        .DRIVER_OUTPUT_ENABLE_N_O(en_n), .RELAY_DRIVE_N_O(drive_n)
    );
    rcs_host_model host_u
    (
        .shift_clk_o(sclk), .data_o(sdata), .sel_n_o(sel_n), .strobe_o(strobe),
        .ident_i(id_wire)
    );
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch reg at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch pin at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request stands until the rising edge that sees waitrequest low, data taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= ~w;
        wr    <= w;
        @(posedge clk);
        while (waitreq !== 1'b0)
            @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic check_all();
        logic [31:0] q;
        for (int c = 0; c < NUM_CARDS; c++)
        begin
            bus(1'b0, 8'(ADDR_RELAY_BASE + ADDR_STEP * c), 32'h0, 4'h0, q);
            chk_reg(q, {16'h0, hi[c], lo[c]});
            chk_pin(32'(drive_n[c*CW +: CW]), {16'h0, hi[c], lo[c]});
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'h0;
        bad_count = 0;
        check_count = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, ADDR_STATUS, 32'h0, 4'h0, r);
        chk_reg(r, 32'h0000003F);
        bus(1'b0, 8'h08, 32'h0, 4'h0, r);
        chk_reg(r, 32'h0);
        chk_pin(drive_n[31:0], 32'hFFFFFFFF);
        chk_pin(32'(id_oe), 32'h0);
        host_u.set_strobe(1'b0);
        repeat (8) @(posedge clk);
        chk_pin(32'(en_n), 32'h3F);
        $display("test power-up done");
        bus(1'b1, ADDR_IDENT_BASE, 32'hFF, 4'h0, r);
        bus(1'b0, ADDR_IDENT_BASE, 32'h0, 4'h0, r);
        chk_reg(r, 32'(IDENT_RST));
        for (int c = 0; c < NUM_CARDS; c++)
        begin
            hi[c] = 8'(8'hA0 + c);
            lo[c] = 8'(8'h50 + c);
            bus(1'b1, 8'(ADDR_IDENT_BASE + ADDR_STEP * c), 32'(8'h90 + c), 4'h1, r);
            bus(1'b0, 8'(ADDR_IDENT_BASE + ADDR_STEP * c), 32'h0, 4'h0, r);
            chk_reg(r, 32'(8'h90 + c));
            host_u.send_byte(~(6'h01 << c), hi[c], id);
            chk_pin(32'(id), 32'(8'h90 + c));
            host_u.send_byte(~(6'h01 << c), lo[c], id);
            chk_pin(32'(id), 32'(8'h90 + c));
        end
        bus(1'b0, ADDR_RELAY_BASE, 32'h0, 4'h0, r);
        // Strobe stood high out of reset, so the latches took the cleared chains then
        chk_reg(r, 32'h00000000);
        bus(1'b1, ADDR_STATUS, 32'h0, 4'hF, r);
        bus(1'b0, ADDR_STATUS, 32'h0, 4'h0, r);
        chk_reg(r, 32'h0000013F);
        host_u.pulse();
        chk_pin(32'(en_n), 32'h0);
        check_all();
        $display("test first load done");
        host_u.send_byte(6'h39, 8'h3C, id);
        host_u.send_byte(6'h39, 8'hC3, id);
        bus(1'b1, ADDR_RELAY_BASE, 32'h0, 4'hF, r);
        check_all();
        hi[1] = 8'h3C;
        lo[1] = 8'hC3;
        hi[2] = 8'h3C;
        lo[2] = 8'hC3;
        host_u.pulse();
        check_all();
        $display("test shared shift done");
        final_report();
    end
endmodule
